// ===== bench/bus_master_chk.sv
// assertions on the handshake bus master ports
`default_nettype none
`include "bus_master_defines.svh"
module bus_master_chk (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // user side
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire logic req_write_i,
    input wire logic req_word_i,
    input wire logic [`ADDR_WIDTH-1:0] req_addr_i,
    input wire logic [`FC_WIDTH-1:0] req_fc_i,
    input wire logic [`DATA_WIDTH-1:0] req_wdata_i,
    input wire logic done_o,
    // bus side
    input wire logic [`ADDR_WIDTH-1:1] addr_o,
    input wire logic addr_oe_o,
    input wire logic [`FC_WIDTH-1:0] fc_o,
    input wire logic read_write_o,
    input wire logic addr_strobe_n_o,
    input wire logic upper_byte_strobe_n_o,
    input wire logic lower_byte_strobe_n_o,
    input wire logic [`DATA_WIDTH-1:0] data_o,
    input wire logic data_oe_o,
    input wire logic transfer_ack_n_i,
    input wire logic bus_fault_n_i
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------
    // sequences and properties
    // ------------------------------------------------------------
    sequence s_take;
        req_valid_i && req_ready_o;
    endsequence
    sequence s_rd_take;
        req_valid_i && req_ready_o && !req_write_i;
    endsequence
    sequence s_wr_take;
        req_valid_i && req_ready_o && req_write_i;
    endsequence
    sequence s_wr_data;
        data_oe_o && upper_byte_strobe_n_o && lower_byte_strobe_n_o && !read_write_o;
    endsequence
    sequence s_hold;
        !addr_strobe_n_o && $stable(addr_o);
    endsequence
    property p_start;
        s_take |=> fc_o == $past(req_fc_i) && read_write_o;
    endproperty
    property p_addr;
        s_take |-> ##2 addr_oe_o && addr_o == $past(req_addr_i[`ADDR_WIDTH-1:1], 2);
    endproperty
    property p_as;
        s_take |-> ##2 addr_strobe_n_o ##1 !addr_strobe_n_o;
    endproperty
    property p_rd_lanes;
        s_rd_take |-> ##3 read_write_o
            && upper_byte_strobe_n_o == ($past(req_addr_i[0], 3) && !$past(req_word_i, 3))
            && lower_byte_strobe_n_o == (!$past(req_addr_i[0], 3) && !$past(req_word_i, 3));
    endproperty
    property p_wr_steps;
        s_wr_take |-> ##4 s_wr_data ##0 data_o == $past(req_wdata_i, 4)
            ##1 !(upper_byte_strobe_n_o && lower_byte_strobe_n_o) && $stable(data_o);
    endproperty
    property p_quiet;
        s_take |-> ##1 !done_o [*8];
    endproperty
    property p_wait;
        (!addr_strobe_n_o && transfer_ack_n_i && bus_fault_n_i) [*6] |=> !addr_strobe_n_o;
    endproperty
    property p_fast;
        $fell(addr_strobe_n_o) && !(transfer_ack_n_i && bus_fault_n_i)
            |-> ##3 s_hold [*2] ##1 $rose(addr_strobe_n_o);
    endproperty
    property p_release;
        $rose(addr_strobe_n_o) |-> upper_byte_strobe_n_o && lower_byte_strobe_n_o
            ##1 !addr_oe_o && !data_oe_o && read_write_o;
    endproperty
    a_start: assert property (p_start) else $error("start lines wrong");
    a_addr: assert property (p_addr) else $error("address late");
    a_as: assert property (p_as) else $error("strobe timing");
    a_rd_lanes: assert property (p_rd_lanes) else $error("read lanes");
    a_wr_steps: assert property (p_wr_steps) else $error("write steps");
    a_quiet: assert property (p_quiet) else $error("short cycle");
    a_wait: assert property (p_wait) else $error("wait lost");
    a_fast: assert property (p_fast) else $error("no fast end");
    a_release: assert property (p_release) else $error("release");
endmodule : bus_master_chk
bind async_handshake_bus_master bus_master_chk i_bus_master_chk (.sys_clk_i, .rst_i,
    .req_valid_i, .req_ready_o, .req_write_i, .req_word_i, .req_addr_i, .req_fc_i,
    .req_wdata_i, .done_o, .addr_o, .addr_oe_o, .fc_o, .read_write_o, .addr_strobe_n_o,
    .upper_byte_strobe_n_o, .lower_byte_strobe_n_o, .data_o, .data_oe_o,
    .transfer_ack_n_i, .bus_fault_n_i);
`default_nettype wire

// ===== bench/bus_slave_model.sv
// synchronous slave memory answering the handshake bus
`default_nettype none
module bus_slave_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus from the master
    input wire logic [22:0] addr_i,
    input wire logic addr_oe_i,
    input wire logic rw_i,
    input wire logic as_n_i,
    input wire logic ub_n_i,
    input wire logic lb_n_i,
    input wire logic [15:0] wdata_i,
    // 0 ack, 1 fault, 2 fault with halt, 3 ack on address
    input wire logic [1:0] mode_i,
    input wire logic [3:0] delay_i,
    // answers
    output logic [15:0] rdata_o,
    output logic ack_n_o,
    output logic fault_n_o,
    output logic halt_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [16];
    logic [3:0] cnt;
    logic [2:0] hcnt;
    logic retried;
    logic active;
    assign active = addr_oe_i && (mode_i == 2'h3 || (!as_n_i && !(ub_n_i && lb_n_i)));
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 4'h0;
            hcnt <= 3'h0;
            retried <= 1'h0;
            ack_n_o <= 1'h1;
            fault_n_o <= 1'h1;
            halt_n_o <= 1'h1;
            rdata_o <= 16'h0000;
        end else if (active) begin
            hcnt <= 3'h0;
            if (cnt != delay_i) begin
                cnt <= cnt + 4'h1;
                rdata_o <= ~rdata_o;
            end else if (mode_i == 2'h1 || (mode_i == 2'h2 && !retried)) begin
                fault_n_o <= 1'h0;
                halt_n_o <= mode_i != 2'h2;
            end else begin
                ack_n_o <= 1'h0;
                if (rw_i) rdata_o <= mem[addr_i[3:0]];
                if (!rw_i && !ub_n_i) mem[addr_i[3:0]][15:8] <= wdata_i[15:8];
                if (!rw_i && !lb_n_i) mem[addr_i[3:0]][7:0] <= wdata_i[7:0];
            end
        end else begin
            cnt <= 4'h0;
            ack_n_o <= 1'h1;
            fault_n_o <= 1'h1;
            rdata_o <= ~rdata_o;
            if (mode_i == 2'h0) retried <= 1'h0;
            if (!halt_n_o) retried <= 1'h1;
            if (!halt_n_o) hcnt <= hcnt + 3'h1;
            if (hcnt == 3'h5) halt_n_o <= 1'h1;
        end
    end
endmodule : bus_slave_model
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the handshake bus master
`default_nettype none
`include "bus_master_defines.svh"
module tb_top import bus_master_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i, rst_i, req_valid_i, req_ready_o, req_write_i, req_word_i;
    logic [`ADDR_WIDTH-1:0] req_addr_i;
    logic [`ADDR_WIDTH-1:1] addr_o;
    logic [`FC_WIDTH-1:0] req_fc_i, fc_o;
    logic [`DATA_WIDTH-1:0] req_wdata_i, rdata_o, data_o, data_i, got_data;
    logic done_o, bus_clk_o, addr_oe_o, read_write_o, data_oe_o;
    logic addr_strobe_n_o, upper_byte_strobe_n_o, lower_byte_strobe_n_o;
    logic transfer_ack_n_i, bus_fault_n_i, halt_n_i;
    logic [1:0] done_kind_o, mode, got_kind;
    logic [3:0] delay;
    int n_fail, checks, got_n;
    async_handshake_bus_master i_async_handshake_bus_master (.sys_clk_i, .rst_i,
        .req_valid_i, .req_ready_o, .req_write_i, .req_word_i, .req_addr_i, .req_fc_i,
        .req_wdata_i, .done_o, .done_kind_o, .rdata_o, .bus_clk_o, .addr_o, .addr_oe_o,
        .fc_o, .read_write_o, .addr_strobe_n_o, .upper_byte_strobe_n_o,
        .lower_byte_strobe_n_o, .data_o, .data_oe_o, .data_i, .transfer_ack_n_i,
        .bus_fault_n_i, .halt_n_i);
    bus_slave_model i_bus_slave_model (.clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_o),
        .addr_oe_i(addr_oe_o), .rw_i(read_write_o), .as_n_i(addr_strobe_n_o),
        .ub_n_i(upper_byte_strobe_n_o), .lb_n_i(lower_byte_strobe_n_o), .wdata_i(data_o),
        .mode_i(mode), .delay_i(delay), .rdata_o(data_i), .ack_n_o(transfer_ack_n_i),
        .fault_n_o(bus_fault_n_i), .halt_n_o(halt_n_i));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        sys_clk_i = 1'h0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    function automatic int exp_n(input logic w, input int d);
        int s;
        s = (w ? 8 : 6) + d;
        return s + 5 - s % 2;
    endfunction : exp_n
    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic xfer(input logic w, input logic wd, input logic [23:0] a,
                        input logic [15:0] d, input logic [1:0] m, input logic [3:0] dl);
        int i;
        @(posedge sys_clk_i);
        {req_valid_i, req_write_i, req_word_i, mode, delay} <= {1'h1, w, wd, m, dl};
        req_addr_i <= a;
        req_wdata_i <= d;
        req_fc_i <= {w, 2'h1};
        i = 0;
        @(negedge sys_clk_i);
        while (req_ready_o !== 1'h1 && i < 20) begin
            @(negedge sys_clk_i);
            i++;
        end
        @(posedge sys_clk_i);
        req_valid_i <= 1'h0;
        // count rising edges from the take up to the one that raises done
        got_n = 1;
        do begin
            @(posedge sys_clk_i);
            got_n++;
            @(negedge sys_clk_i);
        end while (done_o !== 1'h1 && got_n < 300);
        if (i >= 20 || got_n >= 300) begin
            n_fail++;
            tally_and_finish();
        end
        got_kind = done_kind_o;
        got_data = rdata_o;
        @(posedge sys_clk_i);
        mode <= 2'h0;
    endtask : xfer
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_idle;
        @(negedge sys_clk_i);
        chk_val("idle", 16'h0078, {8'h0, bus_clk_o, addr_strobe_n_o, upper_byte_strobe_n_o,
            lower_byte_strobe_n_o, read_write_o, addr_oe_o, data_oe_o, done_o});
        @(negedge sys_clk_i);
        chk_val("bus clock", 16'h0001, {15'h0, bus_clk_o});
        $display("test idle done");
    endtask : t_idle
    task automatic t_words;
        for (int k = 0; k < 4; k++) begin
            xfer(1'h1, 1'h1, 24'(k * 2), 16'hC3A0 + 16'(k), 2'h0, 4'(k * k));
            chk_val("write cycles", 16'(exp_n(1'h1, k * k)), 16'(got_n));
            chk_val("write kind", 16'h0000, {14'h0, got_kind});
            xfer(1'h0, 1'h1, 24'(k * 2), 16'h0000, 2'h0, 4'(k * k));
            chk_val("read data", 16'hC3A0 + 16'(k), got_data);
            chk_val("read cycles", 16'(exp_n(1'h0, k * k)), 16'(got_n));
        end
        $display("test words done");
    endtask : t_words
    task automatic t_lanes;
        xfer(1'h1, 1'h1, 24'h000020, 16'h1111, 2'h0, 4'h0);
        xfer(1'h1, 1'h0, 24'h000020, 16'hAB99, 2'h0, 4'h0);
        xfer(1'h1, 1'h0, 24'h000021, 16'h88CD, 2'h0, 4'h2);
        xfer(1'h0, 1'h1, 24'h000020, 16'h0000, 2'h0, 4'h0);
        chk_val("lane data", 16'hABCD, got_data);
        xfer(1'h0, 1'h0, 24'h000021, 16'h0000, 2'h0, 4'h1);
        chk_val("byte read data", 16'hABCD, got_data);
        $display("test lanes done");
    endtask : t_lanes
    task automatic t_early;
        xfer(1'h0, 1'h1, 24'h000020, 16'h0000, 2'h3, 4'h0);
        chk_val("early data", 16'hABCD, got_data);
        chk_val("early cycles", 16'h0009, 16'(got_n));
        $display("test early done");
    endtask : t_early
    task automatic t_faults;
        xfer(1'h0, 1'h1, 24'h000020, 16'h0000, 2'h1, 4'h3);
        chk_val("fault kind", 16'(END_FAULT), {14'h0, got_kind});
        chk_val("fault cycles", 16'(exp_n(1'h0, 3)), 16'(got_n));
        xfer(1'h0, 1'h1, 24'h000020, 16'h0000, 2'h2, 4'h1);
        chk_val("retry kind", 16'(END_NORMAL), {14'h0, got_kind});
        chk_val("retry data", 16'hABCD, got_data);
        chk_val("retry rerun", 16'h0001, 16'(got_n > exp_n(1'h0, 1)));
        $display("test faults done");
    endtask : t_faults
    initial begin
        rst_i = 1'h1;
        {req_valid_i, req_write_i, req_word_i, mode, delay} = '0;
        req_addr_i = 24'h000000;
        req_wdata_i = 16'h0000;
        req_fc_i = 3'h0;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'h0;
        t_idle();
        t_words();
        t_lanes();
        t_early();
        t_faults();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire

// ===== hdl/async_handshake_bus_master.sv
// bus-master cycle engine for the asynchronous handshake bus
// ----------------------------------------------------------------
// Summary of operation
// - four clocks, eight half states, whole-clock waits
// - S0 drives function code, read/write high
// - S1 drives the address
// - S2 address strobe; read byte strobes, write low
// - S3 write drives data; read unchanged
// - S4 write asserts byte strobes
// - responses ignored until end of S4
// - ack or fault before S4 end advances
// - otherwise back to S3, whole-clock waits
// - no bus output change in S5, S6; done_kind_o updates entering S5
// - S7 captures read data, negates strobes
// - end of S7 floats address, write data
// - no limit on wait for acknowledge
// - ack and fault synchronised to clock
// - read data captured next falling edge
// - early ack gives four-clock transfer
// - fault+halt reruns, fault alone ends
// ----------------------------------------------------------------
// One half state per sys_clk_i rising edge: states S0,S2,S4,S6 are the
// high phases, S1,S3,S5,S7 the low ones; the bus clock is the
// core clock at half rate and is driven out on bus_clk_o.
`default_nettype none
`include "bus_master_defines.svh"
module async_handshake_bus_master
    import bus_master_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // user request side
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_write_i,
    input wire logic req_word_i,
    input wire logic [`ADDR_WIDTH-1:0] req_addr_i,
    input wire logic [`FC_WIDTH-1:0] req_fc_i,
    input wire logic [`DATA_WIDTH-1:0] req_wdata_i,
    // user answer side
    output logic done_o,
    output logic [1:0] done_kind_o,
    output logic [`DATA_WIDTH-1:0] rdata_o,
    // bus clock
    output logic bus_clk_o,
    // bus outputs
    output logic [`ADDR_WIDTH-1:1] addr_o,
    output logic addr_oe_o,
    output logic [`FC_WIDTH-1:0] fc_o,
    output logic read_write_o,
    output logic addr_strobe_n_o,
    output logic upper_byte_strobe_n_o,
    output logic lower_byte_strobe_n_o,
    output logic [`DATA_WIDTH-1:0] data_o,
    output logic data_oe_o,
    // bus inputs
    input wire logic [`DATA_WIDTH-1:0] data_i,
    input wire logic transfer_ack_n_i,
    input wire logic bus_fault_n_i,
    input wire logic halt_n_i
);
    // ------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------
    sync_if sync ();

    input_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ack_n_i(transfer_ack_n_i),
        .fault_n_i(bus_fault_n_i),
        .halt_n_i(halt_n_i),
        .sync(sync)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    bus_state_t state_reg;
    bus_state_t state_next;
    logic write_reg;
    logic write_next;
    logic word_reg;
    logic word_next;
    logic [`ADDR_WIDTH-1:0] taddr_reg;
    logic [`ADDR_WIDTH-1:0] taddr_next;
    logic [`FC_WIDTH-1:0] tfc_reg;
    logic [`FC_WIDTH-1:0] tfc_next;
    logic [`DATA_WIDTH-1:0] twdata_reg;
    logic [`DATA_WIDTH-1:0] twdata_next;
    logic [1:0] kind_reg;
    logic [1:0] kind_next;
    logic retry_reg;
    logic retry_next;
    logic done_reg;
    logic done_next;
    logic [`DATA_WIDTH-1:0] rdata_reg;
    logic [`DATA_WIDTH-1:0] rdata_next;
    logic [`ADDR_WIDTH-1:1] addr_reg;
    logic [`ADDR_WIDTH-1:1] addr_next;
    logic addr_oe_reg;
    logic addr_oe_next;
    logic [`FC_WIDTH-1:0] fc_reg;
    logic [`FC_WIDTH-1:0] fc_next;
    logic rw_reg;
    logic rw_next;
    logic as_n_reg;
    logic as_n_next;
    logic uds_n_reg;
    logic uds_n_next;
    logic lds_n_reg;
    logic lds_n_next;
    logic [`DATA_WIDTH-1:0] dout_reg;
    logic [`DATA_WIDTH-1:0] dout_next;
    logic doe_reg;
    logic doe_next;
    logic phase_reg;
    logic phase_next;
    logic upper_sel;
    logic lower_sel;

    // ------------------------------------------------------------
    // byte lane select
    // ------------------------------------------------------------
    always_comb begin
        upper_sel = word_reg | ~taddr_reg[0];
        lower_sel = word_reg | taddr_reg[0];
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        write_next = write_reg;
        word_next = word_reg;
        taddr_next = taddr_reg;
        tfc_next = tfc_reg;
        twdata_next = twdata_reg;
        kind_next = kind_reg;
        retry_next = retry_reg;
        done_next = 1'b0;
        rdata_next = rdata_reg;
        addr_next = addr_reg;
        addr_oe_next = addr_oe_reg;
        fc_next = fc_reg;
        rw_next = rw_reg;
        as_n_next = as_n_reg;
        uds_n_next = uds_n_reg;
        lds_n_next = lds_n_reg;
        dout_next = dout_reg;
        doe_next = doe_reg;
        phase_next = ~phase_reg;
        case (state_reg)
            ST_IDLE: begin
                // a cycle may only open on a rising edge
                if (phase_reg == `PHASE_LOW) begin
                    if (retry_reg) begin
                        if (!sync.halt) begin
                            retry_next = 1'b0;
                            state_next = ST_S0;
                            fc_next = tfc_reg;
                            rw_next = 1'b1;
                        end
                    end else if (req_valid_i) begin
                        write_next = req_write_i;
                        word_next = req_word_i;
                        taddr_next = req_addr_i;
                        tfc_next = req_fc_i;
                        twdata_next = req_wdata_i;
                        fc_next = req_fc_i;
                        rw_next = 1'b1;
                        state_next = ST_S0;
                    end
                end
            end
            ST_S0: begin
                addr_next = taddr_reg[`ADDR_WIDTH-1:1];
                addr_oe_next = 1'b1;
                state_next = ST_S1;
            end
            ST_S1: begin
                as_n_next = 1'b0;
                if (write_reg) begin
                    rw_next = 1'b0;
                end else begin
                    uds_n_next = ~upper_sel;
                    lds_n_next = ~lower_sel;
                end
                state_next = ST_S2;
            end
            ST_S2: begin
                if (write_reg) begin
                    dout_next = twdata_reg;
                    doe_next = 1'b1;
                end
                state_next = ST_S3;
            end
            ST_S3: begin
                if (write_reg) begin
                    uds_n_next = ~upper_sel;
                    lds_n_next = ~lower_sel;
                end
                state_next = ST_S4;
            end
            ST_S4: begin
                // ack or fault is only looked at on the edge that ends S4
                if (sync.ack || sync.fault) begin
                    state_next = ST_S5;
                    if (sync.fault && sync.halt) begin
                        kind_next = END_RETRY;
                    end else if (sync.fault) begin
                        kind_next = END_FAULT;
                    end else begin
                        kind_next = END_NORMAL;
                    end
                end else begin
                    // stay for one whole clock, then sample again
                    state_next = ST_S3;
                end
            end
            ST_S5: begin
                state_next = ST_S6;
            end
            ST_S6: begin
                if (!write_reg) begin
                    rdata_next = data_i;
                end
                as_n_next = 1'b1;
                uds_n_next = 1'b1;
                lds_n_next = 1'b1;
                state_next = ST_S7;
            end
            ST_S7: begin
                addr_oe_next = 1'b0;
                doe_next = 1'b0;
                rw_next = 1'b1;
                retry_next = (kind_reg == END_RETRY);
                done_next = (kind_reg != END_RETRY);
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            write_reg <= 1'b0;
            word_reg <= 1'b0;
            taddr_reg <= '0;
            tfc_reg <= '0;
            twdata_reg <= '0;
            kind_reg <= END_NORMAL;
            retry_reg <= 1'b0;
            done_reg <= 1'b0;
            rdata_reg <= '0;
            addr_reg <= '0;
            addr_oe_reg <= 1'b0;
            fc_reg <= '0;
            rw_reg <= 1'b1;
            as_n_reg <= 1'b1;
            uds_n_reg <= 1'b1;
            lds_n_reg <= 1'b1;
            dout_reg <= '0;
            doe_reg <= 1'b0;
            phase_reg <= `PHASE_LOW;
        end else begin
            state_reg <= state_next;
            write_reg <= write_next;
            word_reg <= word_next;
            taddr_reg <= taddr_next;
            tfc_reg <= tfc_next;
            twdata_reg <= twdata_next;
            kind_reg <= kind_next;
            retry_reg <= retry_next;
            done_reg <= done_next;
            rdata_reg <= rdata_next;
            addr_reg <= addr_next;
            addr_oe_reg <= addr_oe_next;
            fc_reg <= fc_next;
            rw_reg <= rw_next;
            as_n_reg <= as_n_next;
            uds_n_reg <= uds_n_next;
            lds_n_reg <= lds_n_next;
            dout_reg <= dout_next;
            doe_reg <= doe_next;
            phase_reg <= phase_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign req_ready_o = (state_reg == ST_IDLE) && !retry_reg && (phase_reg == `PHASE_LOW);
    assign done_o = done_reg;
    assign done_kind_o = kind_reg;
    assign rdata_o = rdata_reg;
    assign bus_clk_o = phase_reg;
    assign addr_o = addr_reg;
    assign addr_oe_o = addr_oe_reg;
    assign fc_o = fc_reg;
    assign read_write_o = rw_reg;
    assign addr_strobe_n_o = as_n_reg;
    assign upper_byte_strobe_n_o = uds_n_reg;
    assign lower_byte_strobe_n_o = lds_n_reg;
    assign data_o = dout_reg;
    assign data_oe_o = doe_reg;
endmodule : async_handshake_bus_master
`default_nettype wire

// ===== hdl/bus_master_defines.svh
// timing counts and field positions for the handshake bus master
`ifndef BUS_MASTER_DEFINES_SVH
`define BUS_MASTER_DEFINES_SVH
`define ADDR_WIDTH 24
`define DATA_WIDTH 16
`define FC_WIDTH 3
// one clock period holds two bus states
`define STATES_PER_CLOCK 2
// rising-edge mark of a half state within a clock
`define PHASE_HIGH 1'b1
`define PHASE_LOW 1'b0
`endif

// ===== hdl/bus_master_pkg.sv
// types shared by the handshake bus master files
`default_nettype none
package bus_master_pkg;
    // bus states, one-hot; S0..S7 plus idle
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_S0 = 9'h002,
        ST_S1 = 9'h004,
        ST_S2 = 9'h008,
        ST_S3 = 9'h010,
        ST_S4 = 9'h020,
        ST_S5 = 9'h040,
        ST_S6 = 9'h080,
        ST_S7 = 9'h100
    } bus_state_t;
    // how a transfer ended
    typedef enum logic [1:0] {
        END_NORMAL = 2'h0,
        END_FAULT = 2'h1,
        END_RETRY = 2'h2
    } end_kind_t;
endpackage : bus_master_pkg
`default_nettype wire

// ===== hdl/input_sync.sv
// two-flop synchroniser for the active-low handshake inputs
`default_nettype none
module input_sync (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // raw active-low inputs
    input wire logic ack_n_i,
    input wire logic fault_n_i,
    input wire logic halt_n_i,
    // synchronised active-high levels
    sync_if.producer sync
);
    logic [2:0] stage1_reg;
    logic [2:0] stage1_next;
    logic [2:0] stage2_reg;
    logic [2:0] stage2_next;

    always_comb begin
        stage1_next = {~halt_n_i, ~fault_n_i, ~ack_n_i};
        stage2_next = stage1_reg;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage1_reg <= 3'h0;
            stage2_reg <= 3'h0;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign sync.ack = stage2_reg[0];
    assign sync.fault = stage2_reg[1];
    assign sync.halt = stage2_reg[2];
endmodule : input_sync
`default_nettype wire

// ===== hdl/sync_if.sv
// interface carrying synchronised handshake levels
`default_nettype none
interface sync_if;
    logic ack;
    logic fault;
    logic halt;
    modport producer (output ack, output fault, output halt);
    modport consumer (input ack, input fault, input halt);
endinterface : sync_if
`default_nettype wire
